// ### hw/rvq_defs.svh
// Purpose: Offsets, fields, resets and timing of the ring qualifier.
// Assumes: 8-bit registers on a plain strobe port, 100 MHz clock.
// Notes:   Definitions only; include by bare name.
`ifndef RVQ_DEFS_SVH
`define RVQ_DEFS_SVH

// Register offsets
`define RVQ_ADDR_CTRL1     8'h16
`define RVQ_ADDR_CTRL2     8'h17
`define RVQ_ADDR_CTRL3     8'h18
`define RVQ_ADDR_INT_STAT  8'h20
`define RVQ_ADDR_INT_EN    8'h21
`define RVQ_ADDR_INT_CLR   8'h22
`define RVQ_ADDR_STATE     8'h23

// Reset values
`define RVQ_CTRL1_RST      8'h00
`define RVQ_CTRL2_RST      8'h08
`define RVQ_CTRL3_RST      8'h19
`define RVQ_INT_EN_RST     4'h0

// Field positions
`define RVQ_C1_DLY_LOW     7:6
`define RVQ_C1_MAX_CNT     5:0
`define RVQ_C2_DLY_MSB     7
`define RVQ_C2_TIMEOUT     6:3
`define RVQ_C2_CONFIRM     2:0
`define RVQ_C3_ENABLE      7
`define RVQ_C3_ASSERT      5:0
`define RVQ_C3_WR_MASK     8'hBF

// Event bits of the interrupt status register
`define RVQ_EV_VALID       0
`define RVQ_EV_ENDED       1
`define RVQ_EV_TOO_HIGH    2
`define RVQ_EV_TOO_LOW     3

// Timing
`define RVQ_CLK_PERIOD_NS  10
`define RVQ_TICK_NS        2000000
`define RVQ_TICK_MS        2
`define RVQ_DELAY_STEP_MS  256
`define RVQ_TMO_STEP_MS    128
`define RVQ_CONF0_MS       100
`define RVQ_CONF1_MS       150
`define RVQ_CONF2_MS       200
`define RVQ_CONF3_MS       256
`define RVQ_CONF4_MS       384
`define RVQ_CONF5_MS       512
`define RVQ_CONF6_MS       640
`define RVQ_CONF7_MS       1024

`endif

// ### hw/rvq_pkg.sv
// Purpose: Types shared by the ring qualifier modules.
// Assumes: Constants live in rvq_defs.svh.
// Notes:   State machine codes are one-hot.
`default_nettype none
package rvq_pkg;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } rvq_bus_req_t;

   typedef enum logic [3:0] {
      RVQ_IDLE  = 4'b0001,
      RVQ_QUAL  = 4'b0010,
      RVQ_DELAY = 4'b0100,
      RVQ_VALID = 4'b1000
   } rvq_state_t;

   typedef struct packed {
      logic [7:0] ctrl1;
      logic [7:0] ctrl2;
      logic [7:0] ctrl3;
      logic [3:0] int_stat;
      logic [3:0] int_en;
      logic       irq;
      logic [7:0] rdata;
      logic [2:0] sync;
      rvq_state_t fsm;
      logic       ring_valid;
   } rvq_main_st_t;

   typedef struct packed {
      logic [17:0] count;
      logic        pulse;
   } rvq_tick_st_t;

   typedef struct packed {
      logic [10:0] count;
   } rvq_cnt_st_t;

endpackage
`default_nettype wire

// ### hw/rvq_tick_gen.sv
// Purpose: Free-running timebase giving one pulse per tick period.
// Assumes: TICK_CYCLES fits in 18 bits and is at least 1.
// Notes:   Pulse is one clock wide.
`default_nettype none
module rvq_tick_gen
#(
   parameter int unsigned TICK_CYCLES = 200000
)
(
   // Clock and reset
   input  wire logic clk_sys_i,
   input  wire logic sys_rst_i,
   // Tick
   output logic      tick_o
);
   import rvq_pkg::*;

   rvq_tick_st_t st_q;
   rvq_tick_st_t st_d;

   always_comb
   begin
      st_d       = st_q;
      st_d.pulse = 1'b0;
      if (st_q.count == 18'(TICK_CYCLES - 1))
      begin
         st_d.count = 18'h00000;
         st_d.pulse = 1'b1;
      end
      else
      begin
         st_d.count = st_q.count + 18'h00001;
      end
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (sys_rst_i)
         st_q <= '0;
      else
         st_q <= st_d;
   end

   assign tick_o = st_q.pulse;
endmodule
`default_nettype wire

// ### hw/rvq_tick_cnt.sv
// Purpose: Down counter in timebase ticks, loadable, stops at zero.
// Assumes: Load wins over a tick in the same cycle.
// Notes:   zero_o follows the stored count.
`default_nettype none
module rvq_tick_cnt
(
   // Clock and reset
   input  wire logic        clk_sys_i,
   input  wire logic        sys_rst_i,
   // Control
   input  wire logic        tick_i,
   input  wire logic        load_i,
   input  wire logic [10:0] load_val_i,
   // State
   output logic      [10:0] count_o,
   output logic             zero_o
);
   import rvq_pkg::*;

   rvq_cnt_st_t st_q;
   rvq_cnt_st_t st_d;

   always_comb
   begin
      st_d = st_q;
      if (load_i)
         st_d.count = load_val_i;
      else if (tick_i && (st_q.count != 11'h000))
         st_d.count = st_q.count - 11'h001;
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (sys_rst_i)
         st_q <= '0;
      else
         st_q <= st_d;
   end

   assign count_o = st_q.count;
   assign zero_o  = (st_q.count == 11'h000);
endmodule
`default_nettype wire

// ### hw/rvq_qualifier.sv
// Purpose: Ring-signal qualifier: checks event spacing, confirms,
//          delays and ends a ring, with its control registers.
// Assumes: tip_ring_event_i is asynchronous, high once per crossing.
// Notes:   All times run on one shared 2 ms timebase.
//          The timebase free-runs, so a time may end a tick early.
//          Software keeps the timeout code above zero.
//
// Notes on behaviour
// - Each event reloads timer with assertion time
// - Remaining time above max count: too high
// - Timer ticks every 2.0 ms nominal
// - Event after timer expiry: too low, invalidate
// - Valid only after in-band for confirm time
// - Confirm codes 0-6 give 100 to 640 ms
// - Valid indication held off by delay code
// - Delay code split over two registers
// - Enable bit gates whole qualifier, all modes
//
// Design decision made here: the strobed register port.
`include "rvq_defs.svh"
`default_nettype none
module rvq_qualifier
#(
   parameter int unsigned TICK_CYCLES =
      `RVQ_TICK_NS / `RVQ_CLK_PERIOD_NS
)
(
   // Clock and reset
   input  wire logic                  clk_sys_i,
   input  wire logic                  sys_rst_i,
   // Register port
   input  wire rvq_pkg::rvq_bus_req_t bus_i,
   output logic                [7:0]  rd_data_o,
   // Ring detector
   input  wire logic                  tip_ring_event_i,
   // Results
   output logic                       ring_valid_o,
   output logic                       irq_o
);
   import rvq_pkg::*;

   rvq_main_st_t st_q;
   rvq_main_st_t st_d;

   // Timebase and counters
   logic        tick;
   logic        qual_load;
   logic [10:0] qual_val;
   logic [10:0] qual_count;
   logic        qual_zero;
   logic        phase_load;
   logic [10:0] phase_val;
   logic        phase_zero;
   logic        tmo_load;
   logic [10:0] tmo_val;
   logic        tmo_zero;

   // Decoded fields
   logic [5:0]  max_count;
   logic [5:0]  assert_time;
   logic [2:0]  delay_code;
   logic [3:0]  timeout_code;
   logic [2:0]  confirm_code;
   logic        enable;
   logic        ring_event;
   logic        too_high;
   logic        too_low;
   logic        in_band;
   logic [3:0]  events;

   // Times held in ticks; 11 bits cover the longest delay
   function automatic logic [10:0] ms_to_ticks(input int unsigned ms);
      ms_to_ticks = 11'(ms / `RVQ_TICK_MS);
   endfunction

   function automatic logic [10:0] confirm_ticks(input logic [2:0] code);
      case (code)
         3'h0:    confirm_ticks = ms_to_ticks(`RVQ_CONF0_MS);
         3'h1:    confirm_ticks = ms_to_ticks(`RVQ_CONF1_MS);
         3'h2:    confirm_ticks = ms_to_ticks(`RVQ_CONF2_MS);
         3'h3:    confirm_ticks = ms_to_ticks(`RVQ_CONF3_MS);
         3'h4:    confirm_ticks = ms_to_ticks(`RVQ_CONF4_MS);
         3'h5:    confirm_ticks = ms_to_ticks(`RVQ_CONF5_MS);
         3'h6:    confirm_ticks = ms_to_ticks(`RVQ_CONF6_MS);
         default: confirm_ticks = ms_to_ticks(`RVQ_CONF7_MS);
      endcase
   endfunction

   function automatic logic [10:0] delay_ticks(input logic [2:0] code);
      delay_ticks = ms_to_ticks(32'(code) * `RVQ_DELAY_STEP_MS);
   endfunction

   function automatic logic [10:0] timeout_ticks(input logic [3:0] code);
      timeout_ticks = ms_to_ticks(32'(code) * `RVQ_TMO_STEP_MS);
   endfunction

   // Unmapped offsets and read-only registers drop a write
   function automatic rvq_main_st_t reg_write(input rvq_main_st_t st,
                                              input logic [7:0]   addr,
                                              input logic [7:0]   wdata);
      reg_write = st;
      case (addr)
         `RVQ_ADDR_CTRL1:
            reg_write.ctrl1 = wdata;
         `RVQ_ADDR_CTRL2:
            reg_write.ctrl2 = wdata;
         // Reserved bit is kept at zero
         `RVQ_ADDR_CTRL3:
            reg_write.ctrl3 = wdata & `RVQ_C3_WR_MASK;
         `RVQ_ADDR_INT_EN:
            reg_write.int_en = wdata[3:0];
         // Every bit written as one clears its status bit
         `RVQ_ADDR_INT_CLR:
            reg_write.int_stat = st.int_stat & ~wdata[3:0];
         default:
            reg_write.int_en = st.int_en;
      endcase
   endfunction

   // Unmapped offsets read as zero
   function automatic logic [7:0] reg_read(input rvq_main_st_t st,
                                           input logic [7:0]   addr);
      case (addr)
         `RVQ_ADDR_CTRL1:
            reg_read = st.ctrl1;
         `RVQ_ADDR_CTRL2:
            reg_read = st.ctrl2;
         `RVQ_ADDR_CTRL3:
            reg_read = st.ctrl3;
         `RVQ_ADDR_INT_STAT:
            reg_read = {4'h0, st.int_stat};
         `RVQ_ADDR_INT_EN:
            reg_read = {4'h0, st.int_en};
         `RVQ_ADDR_STATE:
            reg_read = {4'h0, st.fsm};
         default:
            reg_read = 8'h00;
      endcase
   endfunction

   // Shared timebase; a counter load lands anywhere in a tick,
   // which trades one tick of accuracy for a single divider
   rvq_tick_gen
   #(
      .TICK_CYCLES (TICK_CYCLES)
   )
   u_tick
   (
      .clk_sys_i (clk_sys_i),
      .sys_rst_i (sys_rst_i),
      .tick_o    (tick)
   );

   // Spacing timer between crossings
   rvq_tick_cnt u_qual_cnt
   (
      .clk_sys_i  (clk_sys_i),
      .sys_rst_i  (sys_rst_i),
      .tick_i     (tick),
      .load_i     (qual_load),
      .load_val_i (qual_val),
      .count_o    (qual_count),
      .zero_o     (qual_zero)
   );

   // Confirmation time, then validation delay
   rvq_tick_cnt u_phase_cnt
   (
      .clk_sys_i  (clk_sys_i),
      .sys_rst_i  (sys_rst_i),
      .tick_i     (tick),
      .load_i     (phase_load),
      .load_val_i (phase_val),
      .count_o    (),
      .zero_o     (phase_zero)
   );

   // Ring end timeout
   rvq_tick_cnt u_tmo_cnt
   (
      .clk_sys_i  (clk_sys_i),
      .sys_rst_i  (sys_rst_i),
      .tick_i     (tick),
      .load_i     (tmo_load),
      .load_val_i (tmo_val),
      .count_o    (),
      .zero_o     (tmo_zero)
   );

   always_comb
   begin
      max_count    = st_q.ctrl1[`RVQ_C1_MAX_CNT];
      assert_time  = st_q.ctrl3[`RVQ_C3_ASSERT];
      delay_code   = {st_q.ctrl2[`RVQ_C2_DLY_MSB],
                      st_q.ctrl1[`RVQ_C1_DLY_LOW]};
      timeout_code = st_q.ctrl2[`RVQ_C2_TIMEOUT];
      confirm_code = st_q.ctrl2[`RVQ_C2_CONFIRM];
      enable       = st_q.ctrl3[`RVQ_C3_ENABLE];
      // Edge taken behind the second synchroniser stage
      ring_event   = st_q.sync[1] & ~st_q.sync[2];
   end

   always_comb
   begin
      // Judged only on an event after the first one of a ring
      too_high = ring_event && (st_q.fsm != RVQ_IDLE) &&
                 (qual_count > {5'h00, max_count});
      // Timer run out: crossings come too slowly
      too_low  = ring_event && (st_q.fsm != RVQ_IDLE) &&
                 qual_zero;
      in_band  = !too_high && !too_low;
   end

   always_comb
   begin
      st_d       = st_q;
      events     = 4'h0;
      qual_load  = 1'b0;
      qual_val   = {5'h00, assert_time};
      phase_load = 1'b0;
      phase_val  = confirm_ticks(confirm_code);
      tmo_load   = 1'b0;
      tmo_val    = timeout_ticks(timeout_code);

      // Two flip-flops settle the detector level first
      st_d.sync = {st_q.sync[1:0], tip_ring_event_i};

      // Every crossing while enabled restarts spacing timer and end timeout
      if (ring_event && enable)
      begin
         qual_load = 1'b1;
         tmo_load  = 1'b1;
      end

      // Disable first, then timeout, then spacing, then the phase
      case (st_q.fsm)
         RVQ_IDLE:
         begin
            if (ring_event && enable)
            begin
               phase_load = 1'b1;
               st_d.fsm   = RVQ_QUAL;
            end
            else
            begin
               // Waits for a first crossing; ignores all while off
               st_d.fsm = RVQ_IDLE;
            end
         end
         RVQ_QUAL, RVQ_DELAY, RVQ_VALID:
         begin
            if (!enable)
            begin
               st_d.fsm = RVQ_IDLE;
            end
            else if (tmo_zero && !ring_event)
            begin
               // No crossing within the timeout: ring is over
               st_d.fsm          = RVQ_IDLE;
               events[`RVQ_EV_ENDED] = (st_q.fsm == RVQ_VALID);
            end
            else if (!in_band)
            begin
               // Out of band: this crossing starts a new confirmation
               phase_load = 1'b1;
               phase_val  = confirm_ticks(confirm_code);
               st_d.fsm   = RVQ_QUAL;
               events[`RVQ_EV_TOO_HIGH] = too_high;
               events[`RVQ_EV_TOO_LOW]  = too_low;
            end
            else if ((st_q.fsm == RVQ_QUAL) && phase_zero)
            begin
               if (delay_code == 3'h0)
               begin
                  st_d.fsm = RVQ_VALID;
                  events[`RVQ_EV_VALID] = 1'b1;
               end
               else
               begin
                  phase_load = 1'b1;
                  // Delay counts from the end of confirmation
                  phase_val  = delay_ticks(delay_code);
                  st_d.fsm   = RVQ_DELAY;
               end
            end
            else if ((st_q.fsm == RVQ_DELAY) && phase_zero)
            begin
               st_d.fsm = RVQ_VALID;
               events[`RVQ_EV_VALID] = 1'b1;
            end
         end
         default:
         begin
            st_d.fsm = RVQ_IDLE;
         end
      endcase

      st_d.ring_valid = (st_d.fsm == RVQ_VALID);

      // Register writes
      if (bus_i.wr)
      begin
         st_d = reg_write(st_d, bus_i.addr, bus_i.wdata);
      end

      // Setting wins over a clear in the same cycle
      st_d.int_stat = st_d.int_stat | events;
      st_d.irq      = |(st_d.int_stat & st_d.int_en);

      // Read data stand in the following cycle only
      st_d.rdata = 8'h00;
      if (bus_i.rd)
      begin
         st_d.rdata = reg_read(st_q, bus_i.addr);
      end
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (sys_rst_i)
      begin
         st_q            <= '0;
         // Control fields return to their power-up settings
         st_q.ctrl1      <= `RVQ_CTRL1_RST;
         st_q.ctrl2      <= `RVQ_CTRL2_RST;
         st_q.ctrl3      <= `RVQ_CTRL3_RST;
         st_q.int_en     <= `RVQ_INT_EN_RST;
         st_q.fsm        <= RVQ_IDLE;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   // Outputs come straight from the state register
   assign rd_data_o    = st_q.rdata;
   assign ring_valid_o = st_q.ring_valid;
   assign irq_o        = st_q.irq;
endmodule
`default_nettype wire

// ### verification/rvq_qualifier_assertions.sv
// Purpose: Port checks of the ring qualifier.
// Assumes: Bound to rvq_qualifier; read data one cycle late.
// Notes:   Ring timing is judged by the bench.
`include "rvq_defs.svh"
`default_nettype none
module rvq_qualifier_assertions
(
   // Clock and reset
   input wire logic                  clk_sys_i,
   input wire logic                  sys_rst_i,
   // Watched ports
   input wire rvq_pkg::rvq_bus_req_t bus_i,
   input wire logic [7:0]            rd_data_o,
   input wire logic                  tip_ring_event_i,
   input wire logic                  ring_valid_o,
   input wire logic                  irq_o
);
   import rvq_pkg::*;
   default clocking @(posedge clk_sys_i);
   endclocking
   default disable iff (sys_rst_i);

   a_reset_quiet: assert property (disable iff (1'b0)
      $past(sys_rst_i) |-> !ring_valid_o && !irq_o && rd_data_o == 8'h00)
      else $error("outputs busy after reset");
   a_read_idle: assert property (!$past(bus_i.rd) |-> rd_data_o == 8'h00)
      else $error("read data outside read slot");
   a_ctrl_readback: assert property (
      (bus_i.wr && bus_i.addr inside {8'h16, 8'h17}) ##1
      (bus_i.rd && bus_i.addr == $past(bus_i.addr))
      |-> ##1 rd_data_o == $past(bus_i.wdata, 2))
      else $error("control register lost a write");
   a_rsvd_bit: assert property (
      bus_i.rd && bus_i.addr == 8'h18 |=> !rd_data_o[6])
      else $error("reserved bit reads one");
   a_unmapped_zero: assert property (
      bus_i.rd && bus_i.addr > 8'h23 |=> rd_data_o == 8'h00)
      else $error("unmapped read not zero");
   a_state_onehot: assert property (
      bus_i.rd && bus_i.addr == 8'h23 |=> $onehot(rd_data_o))
      else $error("state not one-hot");
   a_irq_masked: assert property (
      (bus_i.wr && bus_i.addr == 8'h21 && bus_i.wdata[3:0] == 4'h0) ##1
      !(bus_i.wr && bus_i.addr == 8'h21) |-> ##1 !irq_o)
      else $error("masked interrupt still high");
   a_disable_drops: assert property (
      bus_i.wr && bus_i.addr == 8'h18 && !bus_i.wdata[7]
      |-> ##[1:3] !ring_valid_o)
      else $error("valid ring kept while disabled");
   c_event: cover property ($rose(tip_ring_event_i));
endmodule
`default_nettype wire

// ### verification/rvq_qualifier_tb.sv
// Purpose: Self-checking bench of the ring qualifier.
// Assumes: Tick cut to T clocks; events 22 ticks apart are in band.
// Notes:   Times judged within a few ticks of timebase jitter.
`include "rvq_defs.svh"
`default_nettype none
module rvq_qualifier_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import rvq_pkg::*;
   localparam int T = 10;
   logic         clk_sys_i = 1'b0;
   logic         sys_rst_i = 1'b1;
   rvq_bus_req_t bus_i     = '0;
   logic         tip_i     = 1'b0;
   logic [7:0]   rd_data_o;
   logic         ring_valid_o;
   logic         irq_o;
   int           mismatches = 0;
   int           n_checks   = 0;
   int           since      = 0;
   int           cf[8] = '{50, 75, 100, 128, 192, 256, 320, 512};
   int           dl[3] = '{1, 2, 7};
   logic [7:0]   ra[7] = '{8'h16, 8'h17, 8'h18, 8'h20, 8'h21, 8'h23, 8'h30};
   logic [7:0]   rv[7] = '{8'h00, 8'h08, 8'h19, 8'h00, 8'h00, 8'h01, 8'h00};

   rvq_qualifier #(.TICK_CYCLES(T)) i_dut
   (
      .clk_sys_i        (clk_sys_i),
      .sys_rst_i        (sys_rst_i),
      .bus_i            (bus_i),
      .rd_data_o        (rd_data_o),
      .tip_ring_event_i (tip_i),
      .ring_valid_o     (ring_valid_o),
      .irq_o            (irq_o)
   );

   initial
   begin
      forever #5 clk_sys_i = ~clk_sys_i;
   end

   task automatic stop_test();
      if (mismatches == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic chk(string n, logic [15:0] e, logic [15:0] g);
      n_checks++;
      if (g !== e)
      begin
         mismatches++;
         $display("BAD %s exp %0h got %0h", n, e, g);
      end
   endtask

   // Returns just after an edge, so callers never clash at one edge
   task automatic tk(int n);
      repeat (n) @(posedge clk_sys_i);
      #1;
   endtask

   task automatic bus(logic w, logic [7:0] a, logic [7:0] d);
      bus_i <= '{w, !w, a, d};
      @(posedge clk_sys_i);
      bus_i <= '0;
      #1;
   endtask

   task automatic rd(logic [7:0] a, logic [7:0] e);
      bus(1'b0, a, 8'h00);
      chk($sformatf("reg %0h", a), e, rd_data_o);
   endtask

   // One crossing, occupying one tick
   task automatic evt();
      tip_i <= 1'b1;
      tk(1);
      tip_i <= 1'b0;
      tk(T - 1);
      since = 0;
   endtask

   task automatic tick();
      tk(T);
      since++;
   endtask

   // In-band crossings until valid; exp in ticks from the first
   task automatic ring(int exp);
      int k;
      k = 0;
      while (ring_valid_o !== 1'b1 && k < exp + 8)
      begin
         if (k % 22 == 0)
            evt();
         else
            tick();
         k++;
      end
      chk("valid ticks", exp, (k > exp - 3 && k < exp + 4) ? exp : k);
      // Bound used up: report now rather than run on
      if (k >= exp + 8)
         stop_test();
   endtask

   task automatic end_ring(int tmo);
      while (ring_valid_o !== 1'b0 && since < tmo + 8)
         tick();
      chk("end ticks", tmo,
          (since > tmo - 3 && since < tmo + 4) ? tmo : since);
      if (since >= tmo + 8)
         stop_test();
      chk("irq", 1, irq_o);
      rd(8'h20, 8'h03);
      bus(1'b1, 8'h22, 8'h0F);
      rd(8'h20, 8'h00);
      chk("irq", 0, irq_o);
   endtask

   initial
   begin
      repeat (100000) @(posedge clk_sys_i);
      mismatches++;
      stop_test();
   end

   initial
   begin
      tk(3);
      sys_rst_i <= 1'b0;
      foreach (ra[i])
         rd(ra[i], rv[i]);
      bus(1'b1, 8'h16, 8'hC5);
      rd(8'h16, 8'hC5);
      bus(1'b1, 8'h17, 8'h80);
      rd(8'h17, 8'h80);
      bus(1'b1, 8'h18, 8'hFF);
      rd(8'h18, 8'hBF);
      bus(1'b1, 8'h18, 8'h99);
      bus(1'b1, 8'h21, 8'h0F);
      bus(1'b1, 8'h16, 8'h05);
      for (int c = 0; c < 8; c++)
      begin
         bus(1'b1, 8'h17, 8'h08 | 8'(c));
         ring(cf[c]);
         end_ring(64);
      end
      foreach (dl[i])
      begin
         bus(1'b1, 8'h16, {dl[i][1:0], 6'h05});
         bus(1'b1, 8'h17, {dl[i][2], 7'h10});
         ring(50 + 128 * dl[i]);
         end_ring(128);
      end
      // Too close, then too far apart; delay code back to zero
      bus(1'b1, 8'h16, 8'h05);
      bus(1'b1, 8'h17, 8'h08);
      evt();
      tk(5 * T);
      evt();
      tk(30 * T);
      evt();
      tk(3);
      rd(8'h20, 8'h0C);
      chk("irq", 1, irq_o);
      bus(1'b1, 8'h22, 8'h0F);
      tk(70 * T);
      rd(8'h23, 8'h01);
      ring(50);
      bus(1'b1, 8'h21, 8'h00);
      tk(1);
      chk("irq", 0, irq_o);
      bus(1'b1, 8'h21, 8'h0F);
      tk(1);
      chk("irq", 1, irq_o);
      bus(1'b1, 8'h18, 8'h19);
      tk(3);
      chk("valid", 0, ring_valid_o);
      evt();
      tk(3);
      rd(8'h23, 8'h01);
      stop_test();
   end
endmodule

bind rvq_qualifier rvq_qualifier_assertions i_chk
(
   .clk_sys_i        (clk_sys_i),
   .sys_rst_i        (sys_rst_i),
   .bus_i            (bus_i),
   .rd_data_o        (rd_data_o),
   .tip_ring_event_i (tip_ring_event_i),
   .ring_valid_o     (ring_valid_o),
   .irq_o            (irq_o)
);
`default_nettype wire
